// ### hdl/cpm_id_lookup.sv
`timescale 1ns/100ps
module cpm_id_lookup #(
  parameter int                 NUM_INST = 2,
  parameter int                 INST_W   = 4,
  parameter cpm_pkg::cpm_arch_e ARCH     = cpm_pkg::ARCH_V1_1,
  parameter logic [4*NUM_INST*16-1:0] PBW_TABLE = {(4*NUM_INST){16'h0010}},
  parameter logic [4*NUM_INST-1:0]    CAPTURE_TABLE = {(4*NUM_INST){1'b1}},
  parameter logic [4*NUM_INST-1:0]    RO_TABLE      = {(4*NUM_INST){1'b0}},
  parameter logic [4*NUM_INST-1:0]    OFSR_TABLE    = {(4*NUM_INST){1'b1}},
  parameter logic [4*NUM_INST*16-1:0] MONITOR_INSTANCE_COUNT_TABLE = {(4*NUM_INST){16'h0008}}
) (
  input  wire logic [4*INST_W-1:0] inst_sel,
  output logic      [4*16-1:0]     portion_width,
  output logic      [4*32-1:0]     usage_mon_word
);

  // ==========================================================
  // one table slice per space; each space reads its own row
  for (genvar s = 0; s < cpm_pkg::NUM_SPACES; s++) begin : g_space
    logic [INST_W-1:0] inst;
    logic [15:0]       pw;
    logic [31:0]       um;
    assign inst = inst_sel[s*INST_W +: INST_W];

    // instance outside the table reads as zero
    // each space builds its own words so one process owns each variable
    always_comb begin
      int idx;
      idx = 0;
      pw  = '0;
      um  = '0;
      if (int'(inst) < NUM_INST) begin
        idx = s*NUM_INST + int'(inst);
        pw = cpm_pkg::cpm_clamp_width(PBW_TABLE[idx*16 +: 16]);
        um[cpm_pkg::CAPTURE_BIT] = CAPTURE_TABLE[idx];
        um[cpm_pkg::RO_BIT]      = RO_TABLE[idx];
        um[cpm_pkg::OFSR_BIT]    =
          OFSR_TABLE[idx] & cpm_pkg::cpm_ofsr_defined(ARCH);
        um[cpm_pkg::MONITOR_INSTANCE_COUNT_LSB +: cpm_pkg::MONITOR_INSTANCE_COUNT_BITS] =
          MONITOR_INSTANCE_COUNT_TABLE[idx*16 +: 16];
      end
    end

    assign portion_width[s*16 +: 16]  = pw;
    assign usage_mon_word[s*32 +: 32] = um;
  end

endmodule

// ### hdl/cpm_id_regs.sv
`timescale 1ns/100ps
module cpm_id_regs #(
  parameter int                 NUM_INST      = 2,
  parameter int                 INST_W        = 4,
  parameter cpm_pkg::cpm_arch_e ARCH          = cpm_pkg::ARCH_V1_1,
  parameter bit                 REALM_PRESENT = 1'b1,
  parameter logic [4*NUM_INST*16-1:0] PBW_TABLE = {(4*NUM_INST){16'h0010}},
  parameter logic [4*NUM_INST-1:0]    CAPTURE_TABLE = {(4*NUM_INST){1'b1}},
  parameter logic [4*NUM_INST-1:0]    RO_TABLE      = {(4*NUM_INST){1'b0}},
  parameter logic [4*NUM_INST-1:0]    OFSR_TABLE    = {(4*NUM_INST){1'b1}},
  parameter logic [4*NUM_INST*16-1:0] MONITOR_INSTANCE_COUNT_TABLE = {(4*NUM_INST){16'h0008}}
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  acc_valid,
  input  wire logic                  acc_write,
  input  wire logic [1:0]            acc_space,
  input  wire logic [15:0]           acc_addr,
  output logic                       acc_ready,
  output logic      [31:0]           acc_rdata,
  output logic                       acc_resp_valid,
  output logic                       acc_resp_err,
  input  wire logic [4*INST_W-1:0]   part_sel_instance,
  input  wire logic [4*16-1:0]       mon_selector,
  output logic      [3:0]            mon_selector_ok,
  output logic      [4*11-1:0]       bitmap_reg_count
);

  // ==========================================================
  // per-space identification values for the selected instance
  logic [4*16-1:0] portion_width;
  logic [4*32-1:0] usage_mon_word;

  cpm_id_lookup #(
    .NUM_INST      (NUM_INST),
    .INST_W        (INST_W),
    .ARCH          (ARCH),
    .PBW_TABLE     (PBW_TABLE),
    .CAPTURE_TABLE (CAPTURE_TABLE),
    .RO_TABLE      (RO_TABLE),
    .OFSR_TABLE    (OFSR_TABLE),
    .MONITOR_INSTANCE_COUNT_TABLE (MONITOR_INSTANCE_COUNT_TABLE)
  ) u_lookup (
    .inst_sel       (part_sel_instance),
    .portion_width  (portion_width),
    .usage_mon_word (usage_mon_word)
  );

  // ==========================================================
  // access sequencer
  cpm_pkg::cpm_state_e state;
  cpm_pkg::cpm_state_e next_state;
  logic                take;

  // one request in flight; the answer cycle blocks the next
  assign acc_ready = (state == cpm_pkg::ST_IDLE);
  assign take      = acc_valid && acc_ready;

  always_comb begin
    next_state = state;
    unique case (state)
      cpm_pkg::ST_IDLE: begin
        if (take)
          next_state = cpm_pkg::ST_ANSWER;
      end
      cpm_pkg::ST_ANSWER: begin
        next_state = cpm_pkg::ST_IDLE;
      end
      default: begin
        next_state = cpm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      state <= cpm_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // address decode and read mux
  logic [1:0]  sp;
  logic        space_open;
  logic        hit_pw;
  logic        hit_um;
  logic [31:0] next_rdata;

  assign sp = acc_space;
  // root and realm pages exist only with the realm feature
  assign space_open = REALM_PRESENT ||
                      (sp == cpm_pkg::SPACE_SECURE) ||
                      (sp == cpm_pkg::SPACE_NONSECURE);
  assign hit_pw = (acc_addr == cpm_pkg::OFS_PORTION_WIDTH_ID);
  assign hit_um = (acc_addr == cpm_pkg::OFS_USAGE_MON_ID);

  // the monitor-select instance field is never looked at here
  always_comb begin
    next_rdata = cpm_pkg::RDATA_RESET;
    if (space_open && hit_pw)
      next_rdata[cpm_pkg::PBW_LSB +: cpm_pkg::PBW_BITS] =
        portion_width[sp*16 +: 16];
    else if (space_open && hit_um)
      next_rdata = usage_mon_word[sp*32 +: 32];
  end

  // ==========================================================
  // answer registers; writes are answered but change nothing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_rdata      <= cpm_pkg::RDATA_RESET;
      acc_resp_valid <= 1'b0;
      acc_resp_err   <= 1'b0;
    end else begin
      acc_resp_valid <= take;
      if (take) begin
        acc_rdata    <= acc_write ? cpm_pkg::RDATA_RESET
                                  : next_rdata;
        acc_resp_err <= !(hit_pw || hit_um);
      end
    end
  end

  // ==========================================================
  // derived status: bitmap word count and selector range check
  for (genvar s = 0; s < cpm_pkg::NUM_SPACES; s++) begin : g_stat
    logic [15:0] nmon;
    logic [10:0] regs_cnt;
    logic        sel_ok;
    assign nmon = usage_mon_word[s*32 + cpm_pkg::MONITOR_INSTANCE_COUNT_LSB +: 16];

    // per-space flops; the output vectors are only wired together below
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        regs_cnt <= '0;
        sel_ok   <= 1'b0;
      end else begin
        regs_cnt <=
          cpm_pkg::cpm_bitmap_regs(portion_width[s*16 +: 16]);
        // zero monitors means no selector value is legal
        sel_ok <= (nmon != 16'h0000) &&
          (mon_selector[s*16 +: 16] <= nmon - 16'h0001);
      end
    end

    assign bitmap_reg_count[s*11 +: 11] = regs_cnt;
    assign mon_selector_ok[s]           = sel_ok;
  end

endmodule

// ### shared/cpm_pkg.sv
package cpm_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] OFS_PORTION_WIDTH_ID = 16'h0030;
  localparam logic [15:0] OFS_USAGE_MON_ID     = 16'h0088;
  localparam int          REG_BITS             = 32;

  // ==========================================================
  // field layout
  localparam int PBW_LSB      = 0;
  localparam int PBW_BITS     = 16;
  localparam int CAPTURE_BIT  = 31;
  localparam int RO_BIT       = 30;
  localparam int OFSR_BIT     = 26;
  localparam int MONITOR_INSTANCE_COUNT_LSB  = 0;
  localparam int MONITOR_INSTANCE_COUNT_BITS = 16;

  // ==========================================================
  // limits and reset values
  localparam logic [15:0] PBW_MIN        = 16'h0001;
  localparam logic [15:0] PBW_MAX        = 16'h8000;
  localparam int          PBM_CNT_BITS   = 11;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
  localparam int          NUM_SPACES     = 4;

  // ==========================================================
  // security spaces, as carried on the access port
  typedef enum logic [1:0] {
    SPACE_SECURE    = 2'h0,
    SPACE_NONSECURE = 2'h1,
    SPACE_ROOT      = 2'h2,
    SPACE_REALM     = 2'h3
  } cpm_space_e;

  // architecture version implemented by the component
  typedef enum logic [1:0] {
    ARCH_V0_1 = 2'h0,
    ARCH_V1_0 = 2'h1,
    ARCH_V1_1 = 2'h2
  } cpm_arch_e;

  // access answer sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h1,
    ST_ANSWER = 2'h2
  } cpm_state_e;

  // ==========================================================
  // helpers
  // width outside 1..32768 is forced into range
  function automatic logic [15:0] cpm_clamp_width(input logic [15:0] w);
    if (w < PBW_MIN)
      return PBW_MIN;
    if (w > PBW_MAX)
      return PBW_MAX;
    return w;
  endfunction

  // 32-bit words needed to hold a bitmap of w bits
  function automatic logic [PBM_CNT_BITS-1:0] cpm_bitmap_regs(
    input logic [15:0] w);
    logic [16:0] sum;
    sum = {1'b0, w} + 17'h0001F;
    return sum[15:5];
  endfunction

  // overflow bitmap indication exists only on 0.1 and 1.1
  function automatic logic cpm_ofsr_defined(input cpm_arch_e a);
    return (a == ARCH_V0_1) || (a == ARCH_V1_1);
  endfunction

endpackage

// ### verif/cpm_id_props.sv
`timescale 1ns/100ps
// ==========================================================
// access port properties
module cpm_id_props (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [15:0] acc_addr,
  input wire logic        acc_ready,
  input wire logic [31:0] acc_rdata,
  input wire logic        acc_resp_valid,
  input wire logic        acc_resp_err
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic tk;
  // a request is taken only while the port is idle
  assign tk = acc_valid && acc_ready;
  a_answer_one_cycle: assert property (tk |=> acc_resp_valid)
    else $error("taken request not answered next cycle");
  a_no_stray_answer: assert property (!tk |=> !acc_resp_valid)
    else $error("answer without request");
  a_answer_pulse_only: assert property (
    acc_resp_valid |=> !acc_resp_valid)
    else $error("answer longer than one cycle");
  a_busy_while_answer: assert property (acc_resp_valid |-> !acc_ready)
    else $error("ready high during answer");
  a_width_upper_zero: assert property (tk && !acc_write &&
    acc_addr == 16'h0030 |=> acc_rdata[31:16] == 16'h0000 && !acc_resp_err)
    else $error("portion width word upper bits set");
  a_usage_gaps_zero: assert property (tk && !acc_write &&
    acc_addr == 16'h0088 |=> acc_rdata[29:27] == 3'h0 &&
    acc_rdata[25:16] == 10'h000 && !acc_resp_err)
    else $error("usage monitor word reserved bits set");
  a_write_reads_zero: assert property (tk && acc_write |=>
    acc_rdata == 32'h0000_0000)
    else $error("write answered with data");
  a_unmapped_flagged: assert property (tk && acc_addr != 16'h0030 &&
    acc_addr != 16'h0088 |=> acc_resp_err && acc_rdata == 32'h0000_0000)
    else $error("unmapped offset not flagged");
  a_data_held: assert property (
    !acc_resp_valid |-> $stable(acc_rdata))
    else $error("read data moved between answers");
  // main scenarios reached
  c_usage_read: cover property (tk && !acc_write && acc_addr == 16'h0088);
  c_write: cover property (tk && acc_write);
  c_err: cover property (acc_resp_valid && acc_resp_err);
endmodule
bind cpm_id_regs cpm_id_props u_props (.ref_clk, .reset_n, .acc_valid,
  .acc_write, .acc_addr, .acc_ready, .acc_rdata, .acc_resp_valid,
  .acc_resp_err);

// ### verif/cpm_id_regs_bench.sv
`timescale 1ns/100ps
module cpm_id_regs_bench;
  // ==========================================================
  // tables differ per space and instance, index space*2+inst
  localparam logic [127:0] PBW  = {16'h0021, 16'h0020, 16'h0005,
    16'h0100, 16'h0040, 16'h0003, 16'h8000, 16'h0001};
  localparam logic [7:0]   CAP  = 8'hA5;
  localparam logic [7:0]   RO   = 8'h69;
  localparam logic [7:0]   OFS  = 8'hC3;
  localparam logic [127:0] NMON = {16'h0001, 16'h0000, 16'h0004,
    16'h0010, 16'h0002, 16'h0003, 16'h0008, 16'hFFFF};
  logic        ref_clk, reset_n, acc_valid, acc_write, acc_ready;
  logic        acc_resp_valid, acc_resp_err;
  logic [1:0]  acc_space;
  logic [15:0] acc_addr, part_sel_instance;
  logic [31:0] acc_rdata;
  logic [63:0] mon_selector;
  logic [3:0]  mon_selector_ok;
  logic [43:0] bitmap_reg_count;
  int          errors, n_compared, i, w;
  logic [15:0] nm;
  cpm_id_regs #(.PBW_TABLE(PBW), .CAPTURE_TABLE(CAP), .RO_TABLE(RO),
    .OFSR_TABLE(OFS), .MONITOR_INSTANCE_COUNT_TABLE(NMON)) u_dut (.ref_clk, .reset_n,
    .acc_valid, .acc_write, .acc_space, .acc_addr, .acc_ready, .acc_rdata,
    .acc_resp_valid, .acc_resp_err, .part_sel_instance, .mon_selector,
    .mon_selector_ok, .bitmap_reg_count);
  // ==========================================================
  // helpers
  function automatic logic [31:0] mw(input int k);
    return {CAP[k], RO[k], 3'h0, OFS[k], 10'h000, NMON[k*16+:16]};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one access; request held until the edge that takes it
  task automatic acc(input logic wr, input logic [1:0] sp,
    input logic [15:0] ad, input logic [31:0] ed, input logic ee);
    int n;
    @(negedge ref_clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_space = sp;
    acc_addr = ad;
    n = 0;
    while (acc_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    acc_valid = 1'b0;
    chk({31'h0, acc_resp_valid}, 32'h1, "answer");
    chk(acc_rdata, ed, "data");
    chk({31'h0, acc_resp_err}, {31'h0, ee}, "err");
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard, far beyond the hundred or so cycles the run needs
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    {reset_n, acc_valid, acc_write, acc_space, acc_addr} = '0;
    {part_sel_instance, mon_selector, errors, n_compared} = '0;
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    chk({31'h0, acc_ready}, 32'h1, "idle ready");
    for (int n = 0; n < 3; n++) begin
      part_sel_instance = {4{4'(n)}};
      for (int s = 0; s < 4; s++) begin
        i = s * 2 + n;
        acc(0, 2'(s), 16'h0030, n < 2 ? {16'h0, PBW[i*16+:16]} : 0, 0);
        acc(0, 2'(s), 16'h0088, n < 2 ? mw(i) : 0, 0);
        acc(1, 2'(s), 16'h0030, 0, 0);
      end
    end
    acc(0, 2'h1, 16'h0034, 0, 1);
    for (int n = 0; n < 2; n++)
      for (int d = 0; d < 2; d++) begin
        part_sel_instance = {4{4'(n)}};
        for (int s = 0; s < 4; s++)
          mon_selector[s*16+:16] = NMON[(s*2+n)*16+:16] - 16'h1 + 16'(d);
        repeat (2) @(negedge ref_clk);
        for (int s = 0; s < 4; s++) begin
          i = s * 2 + n;
          nm = NMON[i*16+:16];
          w = PBW[i*16+:16];
          chk(32'(mon_selector_ok[s]), 32'(nm != 0 && d == 0), "sel");
          chk(32'(bitmap_reg_count[s*11+:11]), 32'((w + 31) / 32), "regs");
        end
      end
    acc(0, 2'h0, 16'h0088, mw(1), 0);
    give_verdict();
  end
endmodule
